/* inc/tkr_defines.vh */
`ifndef TKR_DEFINES_VH
`define TKR_DEFINES_VH

// ==========================================================
// Array geometry.
`define TKR_ADDR_W      11
`define TKR_DATA_W      8
`define TKR_MEM_DEPTH   2048
`define TKR_TOP_PAGE    8'hFF

// ==========================================================
// Clock register addresses.
`define TKR_A_CTRL      11'h7F8
`define TKR_A_SEC       11'h7F9
`define TKR_A_MIN       11'h7FA
`define TKR_A_HOUR      11'h7FB
`define TKR_A_WDAY      11'h7FC
`define TKR_A_DATE      11'h7FD
`define TKR_A_MONTH     11'h7FE
`define TKR_A_YEAR      11'h7FF

// ==========================================================
// Bit positions.
`define TKR_SET_BIT     7
`define TKR_HOLD_BIT    6
`define TKR_HALT_BIT    7
`define TKR_FT_BIT      6

// ==========================================================
// Counter field masks.
`define TKR_M_SEC       8'h7F
`define TKR_M_MIN       8'h7F
`define TKR_M_HOUR      8'h3F
`define TKR_M_WDAY      8'h07
`define TKR_M_DATE      8'h3F
`define TKR_M_MONTH     8'h1F
`define TKR_M_YEAR      8'hFF
`define TKR_M_ALL       8'hFF

// ==========================================================
// Field limits in BCD.
`define TKR_BCD_ZERO    8'h00
`define TKR_BCD_ONE     8'h01
`define TKR_MAX_SEC     8'h59
`define TKR_MAX_HOUR    8'h23
`define TKR_MAX_WDAY    8'h07
`define TKR_MAX_MONTH   8'h12
`define TKR_MAX_YEAR    8'h99
`define TKR_DAYS_31     8'h31
`define TKR_DAYS_30     8'h30
`define TKR_DAYS_29     8'h29
`define TKR_DAYS_28     8'h28
`define TKR_FEB         8'h02
`define TKR_APR         8'h04
`define TKR_JUN         8'h06
`define TKR_SEP         8'h09
`define TKR_NOV         8'h11

// ==========================================================
// Reset values.
`define TKR_RST_CTRL    8'h00
`define TKR_RST_TIME    8'h00
`define TKR_RST_DAY     8'h01

// ==========================================================
// Timebase: core clock rate and test tick rate in Hz.
`define TKR_CLK_HZ      100000000
`define TKR_TICK_HZ     1024
`define TKR_TICK_LAST   10'h3FF

`endif

/* core/tkr_bcd_step.v */
`timescale 1ns/10ps

// ==========================================================
// One BCD field: advance by one, wrap from hi to lo.
module tkr_bcd_step #(
  parameter W = 8
) (
  // Field value and limits
  input  wire [W-1:0] cur,
  input  wire [W-1:0] lo,
  input  wire [W-1:0] hi,
  // Advance request
  input  wire         step,
  // Result
  output wire [W-1:0] nxt,
  output wire         wrap
);

  wire         at_top;
  wire [W-1:0] inc;

  // A value above hi loaded by the host also wraps on its next step.
  assign at_top = (cur >= hi);
  assign inc    = (cur[3:0] == 4'h9) ?
                  {cur[W-1:4] + {{(W-5){1'b0}}, 1'b1}, 4'h0} :
                  {cur[W-1:4], cur[3:0] + 4'h1};
  assign nxt    = !step ? cur : (at_top ? lo : inc);
  assign wrap   = step & at_top;

endmodule // tkr_bcd_step

/* core/tkr_timekeeping_ram.v */
// Behaviour
// R01 - 2K byte array, top eight are clock
// R02 - BCD time and date, 24-hour format
// R03 - Month length and leap year automatic
// R04 - Internal counters never stall on access
// R05 - Power fail deselects the whole device
// R06 - Hold bit stops copy to visible registers
// R07 - Frozen registers keep count at hold
// R08 - Hold clear refreshes all within second
// R09 - Host holds before reading, clears after
// R10 - Set bit freezes, host writes new time
// R11 - Set bit clear loads counters, resumes
// R12 - Seconds MSB one halts the oscillator
// R13 - Test bit toggles seconds LSB 512 Hz
// R14 - Held seconds read shows the toggle
// R15 - Field ranges and widths as specified
// R16 - Unused bits are plain storage bits
// R17 - Calibration writes accepted, no effect
// R18 - Strobe high with select low reads
// R19 - Drive data only on full read
// R20 - Select and strobe low write always
// R21 - Output follows address while enabled
// R22 - Write starts when last enable asserts
`timescale 1ns/10ps
`include "tkr_defines.vh"

module tkr_timekeeping_ram #(
  parameter integer TICK_CYCLES = `TKR_CLK_HZ / `TKR_TICK_HZ
) (
  // Clock and reset
  input  wire                   core_clk,
  input  wire                   rst,
  // Supply monitor
  input  wire                   power_fail,
  // Bus controls
  input  wire                   chip_sel_n,
  input  wire                   out_gate_n,
  input  wire                   wr_strobe_n,
  input  wire [`TKR_ADDR_W-1:0] address_lines,
  // Data lines
  input  wire [`TKR_DATA_W-1:0] data_lines_pin,
  output reg  [`TKR_DATA_W-1:0] data_lines_val,
  output wire                   data_lines_oe
);

  localparam [16:0] TICK_LAST = TICK_CYCLES[16:0] - 17'h00001;

  // ==========================================================
  // Storage.
  reg [`TKR_DATA_W-1:0] mem [0:`TKR_MEM_DEPTH-1];

  reg [7:0]  clock_control_q;
  reg [7:0]  seconds_count_q;
  reg [7:0]  minutes_count_q;
  reg [7:0]  hour_count_q;
  reg [7:0]  weekday_count_q;
  reg [7:0]  date_of_month_q;
  reg [7:0]  month_count_q;
  reg [7:0]  year_count_q;

  reg [7:0]  cnt_sec_q;
  reg [7:0]  cnt_min_q;
  reg [7:0]  cnt_hour_q;
  reg [7:0]  cnt_wday_q;
  reg [7:0]  cnt_date_q;
  reg [7:0]  cnt_mon_q;
  reg [7:0]  cnt_year_q;

  reg [16:0] tick_cnt_q;
  reg [9:0]  frac_cnt_q;
  reg        ft_q;
  reg        set_bit_q;

  // ==========================================================
  // Bus decode.
  wire sel;
  wire wr_act;
  wire rd_act;
  wire top_page;

  assign sel      = !chip_sel_n & !power_fail;              // [R05]
  assign wr_act   = sel & !wr_strobe_n;                     // [R20] [R22]
  assign rd_act   = sel & wr_strobe_n;                      // [R18]
  assign top_page = (address_lines[10:3] == `TKR_TOP_PAGE); // [R01]

  assign data_lines_oe = rd_act & !out_gate_n;              // [R19]

  wire wr_ctrl;
  wire wr_sec;
  wire wr_min;
  wire wr_hour;
  wire wr_wday;
  wire wr_date;
  wire wr_mon;
  wire wr_year;

  assign wr_ctrl = wr_act & (address_lines == `TKR_A_CTRL);
  assign wr_sec  = wr_act & (address_lines == `TKR_A_SEC);
  assign wr_min  = wr_act & (address_lines == `TKR_A_MIN);
  assign wr_hour = wr_act & (address_lines == `TKR_A_HOUR);
  assign wr_wday = wr_act & (address_lines == `TKR_A_WDAY);
  assign wr_date = wr_act & (address_lines == `TKR_A_DATE);
  assign wr_mon  = wr_act & (address_lines == `TKR_A_MONTH);
  assign wr_year = wr_act & (address_lines == `TKR_A_YEAR);

  // ==========================================================
  // Mode bits.
  wire freeze;
  wire osc_run;
  wire ft_on;
  wire set_fall;

  assign freeze   = clock_control_q[`TKR_HOLD_BIT] |
                    clock_control_q[`TKR_SET_BIT] | set_fall; // [R06] [R10] [R11]
  assign osc_run  = !seconds_count_q[`TKR_HALT_BIT];        // [R12]
  assign ft_on    = weekday_count_q[`TKR_FT_BIT] & osc_run; // [R13]
  assign set_fall = set_bit_q & !clock_control_q[`TKR_SET_BIT];

  // ==========================================================
  // Timebase.
  wire tick;
  wire sec_tick;

  assign tick     = osc_run & (tick_cnt_q == TICK_LAST);
  assign sec_tick = tick & (frac_cnt_q == `TKR_TICK_LAST);

  always @(posedge core_clk) begin
    if (rst) begin
      tick_cnt_q <= 17'h00000;
      frac_cnt_q <= 10'h000;
      ft_q       <= 1'b0;
    end else if (osc_run) begin                             // [R12]
      if (tick) begin
        tick_cnt_q <= 17'h00000;
        frac_cnt_q <= frac_cnt_q + 10'h001;
        // Two flips per period, so a 1024 Hz tick gives 512 Hz.
        ft_q       <= ~ft_q;                                // [R13]
      end else begin
        tick_cnt_q <= tick_cnt_q + 17'h00001;
      end
    end
  end

  // ==========================================================
  // Calendar chain.
  reg  [7:0] days_max;
  wire       leap;

  // Years 00 to 99 only; 2000 is leap, so no century rule is needed.
  assign leap = cnt_year_q[4] ?
                (cnt_year_q[3:0] == 4'h2 || cnt_year_q[3:0] == 4'h6) :
                (cnt_year_q[3:0] == 4'h0 || cnt_year_q[3:0] == 4'h4 ||
                 cnt_year_q[3:0] == 4'h8);                  // [R03]

  always @* begin
    case (cnt_mon_q)
      `TKR_FEB: days_max = leap ? `TKR_DAYS_29 : `TKR_DAYS_28; // [R03]
      `TKR_APR,
      `TKR_JUN,
      `TKR_SEP,
      `TKR_NOV: days_max = `TKR_DAYS_30;
      default:  days_max = `TKR_DAYS_31;
    endcase
  end

  wire [7:0] sec_nxt;
  wire [7:0] min_nxt;
  wire [7:0] hour_nxt;
  wire [7:0] wday_nxt;
  wire [7:0] date_nxt;
  wire [7:0] mon_nxt;
  wire [7:0] year_nxt;
  wire       sec_wrap;
  wire       min_wrap;
  wire       hour_wrap;
  wire       date_wrap;
  wire       mon_wrap;

  // Field limits follow the allowed BCD ranges.
  tkr_bcd_step #(.W(8)) u_sec (
    .cur  (cnt_sec_q),
    .lo   (`TKR_BCD_ZERO),
    .hi   (`TKR_MAX_SEC),
    .step (sec_tick),
    .nxt  (sec_nxt),
    .wrap (sec_wrap)
  );                                                        // [R02] [R15]

  tkr_bcd_step #(.W(8)) u_min (
    .cur  (cnt_min_q),
    .lo   (`TKR_BCD_ZERO),
    .hi   (`TKR_MAX_SEC),
    .step (sec_wrap),
    .nxt  (min_nxt),
    .wrap (min_wrap)
  );                                                        // [R15]

  tkr_bcd_step #(.W(8)) u_hour (
    .cur  (cnt_hour_q),
    .lo   (`TKR_BCD_ZERO),
    .hi   (`TKR_MAX_HOUR),
    .step (min_wrap),
    .nxt  (hour_nxt),
    .wrap (hour_wrap)
  );                                                        // [R02]

  tkr_bcd_step #(.W(8)) u_wday (
    .cur  (cnt_wday_q),
    .lo   (`TKR_BCD_ONE),
    .hi   (`TKR_MAX_WDAY),
    .step (hour_wrap),
    .nxt  (wday_nxt),
    .wrap ()
  );                                                        // [R15]

  tkr_bcd_step #(.W(8)) u_date (
    .cur  (cnt_date_q),
    .lo   (`TKR_BCD_ONE),
    .hi   (days_max),
    .step (hour_wrap),
    .nxt  (date_nxt),
    .wrap (date_wrap)
  );                                                        // [R03]

  tkr_bcd_step #(.W(8)) u_mon (
    .cur  (cnt_mon_q),
    .lo   (`TKR_BCD_ONE),
    .hi   (`TKR_MAX_MONTH),
    .step (date_wrap),
    .nxt  (mon_nxt),
    .wrap (mon_wrap)
  );                                                        // [R15]

  tkr_bcd_step #(.W(8)) u_year (
    .cur  (cnt_year_q),
    .lo   (`TKR_BCD_ZERO),
    .hi   (`TKR_MAX_YEAR),
    .step (mon_wrap),
    .nxt  (year_nxt),
    .wrap ()
  );                                                        // [R15]

  // ==========================================================
  // Internal counters.
  // Only the set bit clearing touches them, so no access loses time.
  always @(posedge core_clk) begin
    if (rst) begin
      cnt_sec_q  <= `TKR_RST_TIME;
      cnt_min_q  <= `TKR_RST_TIME;
      cnt_hour_q <= `TKR_RST_TIME;
      cnt_wday_q <= `TKR_RST_DAY;
      cnt_date_q <= `TKR_RST_DAY;
      cnt_mon_q  <= `TKR_RST_DAY;
      cnt_year_q <= `TKR_RST_TIME;
      set_bit_q  <= 1'b0;
    end else begin
      set_bit_q <= clock_control_q[`TKR_SET_BIT];
      if (set_fall) begin                                   // [R11]
        cnt_sec_q  <= seconds_count_q & `TKR_M_SEC;
        cnt_min_q  <= minutes_count_q & `TKR_M_MIN;
        cnt_hour_q <= hour_count_q & `TKR_M_HOUR;
        cnt_wday_q <= weekday_count_q & `TKR_M_WDAY;
        cnt_date_q <= date_of_month_q & `TKR_M_DATE;
        cnt_mon_q  <= month_count_q & `TKR_M_MONTH;
        cnt_year_q <= year_count_q & `TKR_M_YEAR;
      end else begin                                        // [R04] [R07]
        cnt_sec_q  <= sec_nxt;
        cnt_min_q  <= min_nxt;
        cnt_hour_q <= hour_nxt;
        cnt_wday_q <= wday_nxt;
        cnt_date_q <= date_nxt;
        cnt_mon_q  <= mon_nxt;
        cnt_year_q <= year_nxt;
      end
    end
  end

  // ==========================================================
  // Visible clock registers.
  // Copying every unfrozen cycle refreshes all fields at once,
  // well inside a second; unused bits keep what the host wrote.
  always @(posedge core_clk) begin
    if (rst) begin
      clock_control_q <= `TKR_RST_CTRL;
      seconds_count_q <= `TKR_RST_TIME;
      minutes_count_q <= `TKR_RST_TIME;
      hour_count_q    <= `TKR_RST_TIME;
      weekday_count_q <= `TKR_RST_DAY;
      date_of_month_q <= `TKR_RST_DAY;
      month_count_q   <= `TKR_RST_DAY;
      year_count_q    <= `TKR_RST_TIME;
    end else begin
      // Low control bits are kept but drive nothing.
      if (wr_ctrl)
        clock_control_q <= data_lines_pin;                  // [R17] [R16]
      if (wr_sec)
        seconds_count_q <= data_lines_pin;                  // [R10] [R12]
      else if (!freeze)
        seconds_count_q <= (seconds_count_q & ~`TKR_M_SEC) |
                           (cnt_sec_q & `TKR_M_SEC);        // [R08] [R16]
      if (wr_min)
        minutes_count_q <= data_lines_pin;
      else if (!freeze)
        minutes_count_q <= (minutes_count_q & ~`TKR_M_MIN) |
                           (cnt_min_q & `TKR_M_MIN);        // [R08]
      if (wr_hour)
        hour_count_q <= data_lines_pin;
      else if (!freeze)
        hour_count_q <= (hour_count_q & ~`TKR_M_HOUR) |
                        (cnt_hour_q & `TKR_M_HOUR);         // [R08]
      if (wr_wday)
        weekday_count_q <= data_lines_pin;
      else if (!freeze)
        weekday_count_q <= (weekday_count_q & ~`TKR_M_WDAY) |
                           (cnt_wday_q & `TKR_M_WDAY);      // [R16]
      if (wr_date)
        date_of_month_q <= data_lines_pin;
      else if (!freeze)
        date_of_month_q <= (date_of_month_q & ~`TKR_M_DATE) |
                           (cnt_date_q & `TKR_M_DATE);      // [R08]
      if (wr_mon)
        month_count_q <= data_lines_pin;
      else if (!freeze)
        month_count_q <= (month_count_q & ~`TKR_M_MONTH) |
                         (cnt_mon_q & `TKR_M_MONTH);        // [R08]
      if (wr_year)
        year_count_q <= data_lines_pin;
      else if (!freeze)
        year_count_q <= cnt_year_q & `TKR_M_ALL;            // [R08]
    end
  end

  // ==========================================================
  // Plain storage.
  always @(posedge core_clk) begin
    if (wr_act && !top_page)
      mem[address_lines] <= data_lines_pin;                 // [R01] [R20]
  end

  // ==========================================================
  // Read path.
  // Data is resampled every cycle, so it follows the address and
  // the test toggle without a new strobe, one cycle behind.
  reg [7:0] rd_mux;

  always @* begin
    case (address_lines)
      `TKR_A_CTRL:  rd_mux = clock_control_q;
      `TKR_A_SEC:   rd_mux = ft_on ?
                             {seconds_count_q[7:1], ft_q} :
                             seconds_count_q;               // [R14]
      `TKR_A_MIN:   rd_mux = minutes_count_q;
      `TKR_A_HOUR:  rd_mux = hour_count_q;
      `TKR_A_WDAY:  rd_mux = weekday_count_q;
      `TKR_A_DATE:  rd_mux = date_of_month_q;
      `TKR_A_MONTH: rd_mux = month_count_q;
      `TKR_A_YEAR:  rd_mux = year_count_q;
      default:      rd_mux = `TKR_RST_CTRL;
    endcase
  end

  always @(posedge core_clk) begin
    data_lines_val <= top_page ? rd_mux : mem[address_lines]; // [R21]
  end

endmodule // tkr_timekeeping_ram

/* tb/tkr_timekeeping_ram_monitor.sv */
`timescale 1ns/10ps
`include "tkr_defines.vh"

module tkr_timekeeping_ram_monitor (
  // Clock and reset
  input wire        core_clk,
  input wire        rst,
  // Bus
  input wire        power_fail,
  input wire        chip_sel_n,
  input wire        out_gate_n,
  input wire        wr_strobe_n,
  input wire [10:0] address_lines,
  input wire [7:0]  data_lines_pin,
  input wire [7:0]  data_lines_val,
  input wire        data_lines_oe
);
  // ==========================================================
  // Helpers.
  wire w_ok = !chip_sel_n && !wr_strobe_n && !power_fail;
  wire ram  = address_lines < `TKR_A_CTRL;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Checks.
  AST_OE_EQ: assert property (data_lines_oe ==
    (!chip_sel_n && !out_gate_n && wr_strobe_n && !power_fail))
    else $error("data drive does not match bus controls");
  AST_PF_DESEL: assert property (power_fail |-> !data_lines_oe)
    else $error("data driven during power fail");
  AST_WR_NO_DRIVE: assert property ((!chip_sel_n && !wr_strobe_n) |-> !data_lines_oe)
    else $error("data driven during write");
  AST_DESEL: assert property (chip_sel_n |-> !data_lines_oe)
    else $error("data driven while deselected");
  AST_RAM_WR: assert property ((w_ok && ram) ##1 (!w_ok && $stable(address_lines))
    |=> data_lines_val == $past(data_lines_pin, 2))
    else $error("written byte not read back");
  AST_RAM_STABLE: assert property ((!w_ok && ram) ##1 (!w_ok && $stable(address_lines))
    |=> $stable(data_lines_val))
    else $error("stored byte changed without write");
  AST_PF_NO_WR: assert property ((power_fail && !chip_sel_n && !wr_strobe_n && ram)
    ##1 (!w_ok && $stable(address_lines)) |=> $stable(data_lines_val))
    else $error("write taken during power fail");
  AST_RST_CTRL: assert property (($fell(rst) && address_lines == `TKR_A_CTRL)
    |=> data_lines_val == 8'h00)
    else $error("control byte not cleared by reset");
endmodule // tkr_timekeeping_ram_monitor

bind tkr_timekeeping_ram tkr_timekeeping_ram_monitor mon (.core_clk(core_clk), .rst(rst),
  .power_fail(power_fail), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
  .wr_strobe_n(wr_strobe_n), .address_lines(address_lines), .data_lines_pin(data_lines_pin),
  .data_lines_val(data_lines_val), .data_lines_oe(data_lines_oe));

/* tb/tkr_host_model.sv */
`timescale 1ns/10ps

module tkr_host_model (
  // Clock
  input  wire        core_clk,
  // Bus controls
  output reg         chip_sel_n,
  output reg         out_gate_n,
  output reg         wr_strobe_n,
  output reg  [10:0] address_lines,
  // Data
  output reg  [7:0]  host_d,
  input  wire [7:0]  data_lines_val
);
  initial begin
    chip_sel_n = 1'b1;
    out_gate_n = 1'b1;
    wr_strobe_n = 1'b1;
    address_lines = 11'h7F8;
    host_d = 8'h00;
  end

  // ==========================================================
  // Address stays put from the select edge until the strobe is released.
  task wr(input [10:0] a, input [7:0] d, input og);
    begin
      @(posedge core_clk);
      address_lines <= a;
      host_d <= d;
      out_gate_n <= og;
      chip_sel_n <= 1'b0;
      wr_strobe_n <= 1'b0;
      @(posedge core_clk);
      chip_sel_n <= 1'b1;
      wr_strobe_n <= 1'b1;
      out_gate_n <= 1'b1;
      host_d <= ~d;
    end
  endtask

  // Select stays low after a read, so later reads flow through.
  task rd(input [10:0] a, output [7:0] d);
    begin
      @(posedge core_clk);
      address_lines <= a;
      wr_strobe_n <= 1'b1;
      chip_sel_n <= 1'b0;
      out_gate_n <= 1'b0;
      @(posedge core_clk);
      #1 d = data_lines_val;
    end
  endtask
endmodule // tkr_host_model

/* tb/tkr_timekeeping_ram_tb_top.sv */
`timescale 1ns/10ps
`include "tkr_defines.vh"

module tkr_timekeeping_ram_tb_top;
  // ==========================================================
  // Signals.
  reg         core_clk;
  reg         rst;
  reg         power_fail;
  wire        chip_sel_n;
  wire        out_gate_n;
  wire        wr_strobe_n;
  wire [10:0] address_lines;
  wire [7:0]  host_d;
  wire [7:0]  data_lines_val;
  wire        data_lines_oe;
  wire [7:0]  wire_lvl;
  integer     n_fail;
  integer     num_checks;
  integer     i;
  integer     k;
  integer     n;
  reg  [31:0] lfsr;
  reg  [7:0]  d;
  reg  [7:0]  s0;
  reg  [7:0]  ed;
  reg  [7:0]  em;
  reg  [7:0]  ey;
  reg  [7:0]  mem_m [0:2047];
  reg  [10:0] aq [0:15];
  reg  [23:0] tc [0:3];

  // A released host leaves its last byte inverted on the bus, never a lucky match.
  assign wire_lvl = data_lines_oe ? data_lines_val : host_d;

  tkr_timekeeping_ram #(.TICK_CYCLES(4)) dut (.core_clk(core_clk), .rst(rst),
    .power_fail(power_fail), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
    .wr_strobe_n(wr_strobe_n), .address_lines(address_lines), .data_lines_pin(wire_lvl),
    .data_lines_val(data_lines_val), .data_lines_oe(data_lines_oe));
  tkr_host_model host (.core_clk(core_clk), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
    .wr_strobe_n(wr_strobe_n), .address_lines(address_lines), .host_d(host_d),
    .data_lines_val(data_lines_val));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================
  // Expectation helpers.
  function [31:0] lfsr_next(input [31:0] x);
    lfsr_next = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  function [7:0] bcd_inc(input [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction
  function [7:0] days_in(input [7:0] m, input [7:0] y);
    if (m == 8'h02)
      days_in = (y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                      : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) ? 8'h29 : 8'h28;
    else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
      days_in = 8'h30;
    else
      days_in = 8'h31;
  endfunction

  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task toggles(output integer c);
    reg b;
    begin
      c = 0;
      b = data_lines_val[0];
      repeat (64) begin
        @(posedge core_clk);
        #1 if (data_lines_val[0] !== b) c = c + 1;
        b = data_lines_val[0];
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    n_fail = 0;
    num_checks = 0;
    lfsr = 32'h1BF8;
    rst = 1'b1;
    power_fail = 1'b0;
    tc[0] = {8'h01, 8'h28, 8'h02};
    tc[1] = {8'h04, 8'h28, 8'h02};
    tc[2] = {8'h01, 8'h30, 8'h04};
    tc[3] = {8'h99, 8'h31, 8'h12};
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      host.rd(`TKR_A_CTRL + i, d);
      chk(d, (i > 3 && i < 7) ? `TKR_RST_DAY : `TKR_RST_TIME);
    end
    for (i = 0; i < 16; i = i + 1) begin
      lfsr = lfsr_next(lfsr);
      aq[i] = lfsr[10:0] & 11'h7F7;
      mem_m[aq[i]] = lfsr[23:16];
      host.wr(aq[i], lfsr[23:16], i[0]);
    end
    for (i = 15; i >= 0; i = i - 1) begin
      host.rd(aq[i], d);
      chk(d, mem_m[aq[i]]);
    end
    @(posedge core_clk) power_fail <= 1'b1;
    host.wr(aq[0], ~mem_m[aq[0]], 1'b1);
    host.rd(aq[0], d);
    chk({7'h00, data_lines_oe}, 8'h00);
    @(posedge core_clk) power_fail <= 1'b0;
    host.rd(aq[0], d);
    chk(d, mem_m[aq[0]]);
    for (k = 0; k < 4; k = k + 1) begin
      {ey, ed, em} = tc[k];
      host.wr(`TKR_A_CTRL, 8'hBF, 1'b1);
      host.wr(`TKR_A_SEC, 8'h59, 1'b1);
      host.wr(`TKR_A_MIN, 8'h59, 1'b1);
      host.wr(`TKR_A_HOUR, 8'h23, 1'b1);
      host.wr(`TKR_A_WDAY, 8'h07, 1'b1);
      host.wr(`TKR_A_DATE, ed | 8'hC0, 1'b1);
      host.wr(`TKR_A_MONTH, em | 8'hE0, 1'b1);
      host.wr(`TKR_A_YEAR, ey, 1'b1);
      host.wr(`TKR_A_CTRL, 8'h3F, 1'b1);
      n = 0;
      d = 8'h59;
      while (d !== 8'h00 && n < 3000) begin
        host.rd(`TKR_A_SEC, d);
        n = n + 1;
      end
      if (n >= 3000) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t seconds never rolled over", $time);
        end_sim;
      end
      host.wr(`TKR_A_CTRL, 8'h7F, 1'b1);
      if (ed == days_in(em, ey)) begin
        ed = 8'h01;
        if (em == 8'h12) ey = (ey == 8'h99) ? 8'h00 : bcd_inc(ey);
        em = (em == 8'h12) ? 8'h01 : bcd_inc(em);
      end else
        ed = bcd_inc(ed);
      host.rd(`TKR_A_MIN, d);
      chk(d, 8'h00);
      host.rd(`TKR_A_HOUR, d);
      chk(d, 8'h00);
      host.rd(`TKR_A_WDAY, d);
      chk(d, 8'h01);
      host.rd(`TKR_A_DATE, d);
      chk(d, ed | 8'hC0);
      host.rd(`TKR_A_MONTH, d);
      chk(d, em | 8'hE0);
      host.rd(`TKR_A_YEAR, d);
      chk(d, ey);
      host.rd(`TKR_A_CTRL, d);
      chk(d, 8'h7F);
    end
    host.rd(`TKR_A_SEC, s0);
    repeat (8192) @(posedge core_clk);
    host.rd(`TKR_A_SEC, d);
    chk(d, s0);
    host.wr(`TKR_A_CTRL, 8'h3F, 1'b1);
    host.rd(`TKR_A_SEC, d);
    s0 = bcd_inc(bcd_inc(s0));
    chk(d, s0);
    host.wr(`TKR_A_CTRL, 8'hBF, 1'b1);
    host.wr(`TKR_A_WDAY, 8'h41, 1'b1);
    host.wr(`TKR_A_CTRL, 8'h3F, 1'b1);
    host.rd(`TKR_A_SEC, d);
    toggles(n);
    chk({7'h00, n >= 14 && n <= 18}, 8'h01);
    host.wr(`TKR_A_CTRL, 8'hBF, 1'b1);
    host.wr(`TKR_A_SEC, 8'h80, 1'b1);
    host.wr(`TKR_A_CTRL, 8'h3F, 1'b1);
    host.rd(`TKR_A_SEC, d);
    toggles(n);
    chk(n[7:0], 8'h00);
    repeat (5000) @(posedge core_clk);
    host.rd(`TKR_A_SEC, d);
    chk(d, 8'h80);
    end_sim;
  end
endmodule // tkr_timekeeping_ram_tb_top
